// File: hdl/mem_pins_pkg.sv
package mem_pins_pkg;
    localparam int ADDR_W      = 24;
    localparam int MA_W        = 12;
    localparam int ROW_W       = 11;
    localparam int DATA_W      = 16;
    localparam int BANKS       = 2;
    localparam int BIOS_WINS   = 5;
    // direct bios windows, 64k each, compared on address bits 23:16
    localparam logic [7:0] WIN_F0 = 8'h0F;
    localparam logic [7:0] WIN_E0 = 8'h0E;
    localparam logic [7:0] WIN_D0 = 8'h0D;
    localparam logic [7:0] WIN_C0 = 8'h0C;
    localparam logic [7:0] WIN_A0 = 8'h0A;
    localparam logic [7:0] BOOT_SEG = 8'hFF;
    localparam int SEG_LSB     = 16;
    localparam int SA_HI_LSB   = 12;

    typedef enum logic [1:0] {
        CYC_MAIN  = 2'h0,
        CYC_LOCAL = 2'h1,
        CYC_IO    = 2'h2,
        CYC_EXT   = 2'h3
    } cyc_kind_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [1:0]        byte_en;
        logic              write;
        cyc_kind_t         kind;
    } bus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ROW  = 2'b01,
        ST_COL  = 2'b11,
        ST_END  = 2'b10
    } dram_st_t;
endpackage

// File: hdl/memory_bus_pin_interface.sv
`timescale 1ns/100ps
module memory_bus_pin_interface
#(
    parameter int ADDR_W = mem_pins_pkg::ADDR_W
)
(
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_ce,
    input  wire logic                  i_req_valid,
    input  wire mem_pins_pkg::bus_req_t i_req,
    input  wire logic [15:0]           i_core_wdata,
    input  wire logic                  i_sram_mode,
    input  wire logic                  i_bios_paged,
    input  wire logic                  i_os_paged,
    input  wire logic                  i_paged_bios_hit,
    input  wire logic                  i_paged_os_hit,
    input  wire logic                  i_os_direct_hit,
    input  wire logic [4:0]            i_bios_win_en,
    input  wire logic [15:0]           i_sys_data_bus_in,
    output logic                       o_busy,
    output logic [15:0]                o_core_rdata,
    output logic                       o_rdata_valid,
    output logic [3:0]                 o_col_strobe_n,
    output logic [1:0]                 o_row_strobe_n,
    output logic [11:0]                o_mem_addr_out,
    output logic [11:0]                o_sys_addr_low,
    output logic                       o_mem_write_strobe_n,
    output logic                       o_bios_rom_select_n,
    output logic                       o_os_rom_select_n,
    output logic [15:0]                o_sys_data_bus_out,
    output logic                       o_sys_data_bus_oe
);
    mem_pins_pkg::dram_st_t state;
    mem_pins_pkg::bus_req_t cur;

    function automatic logic seg_is(input logic [23:0] a,
                                    input logic [7:0] seg);
        seg_is = (a[23:mem_pins_pkg::SEG_LSB] == seg);
    endfunction

    function automatic logic bios_hit(input logic [23:0] a,
                                      input logic [4:0] en,
                                      input logic paged,
                                      input logic paged_hit);
        logic d;
        d = (en[4] && seg_is(a, mem_pins_pkg::WIN_F0))
          | (en[3] && seg_is(a, mem_pins_pkg::WIN_E0))
          | (en[2] && seg_is(a, mem_pins_pkg::WIN_D0))
          | (en[1] && seg_is(a, mem_pins_pkg::WIN_C0))
          | (en[0] && seg_is(a, mem_pins_pkg::WIN_A0));
        // boot vector segment always reaches the bios rom
        bios_hit = seg_is(a, mem_pins_pkg::BOOT_SEG)
                 | (paged ? paged_hit : d);
    endfunction

    logic bios_sel;
    logic os_sel;
    logic is_main;
    logic bank;

    always_comb
    begin
        bios_sel = bios_hit(cur.addr, i_bios_win_en, i_bios_paged,
                            i_paged_bios_hit);
        os_sel = (i_os_paged ? i_paged_os_hit : i_os_direct_hit)
                 && !bios_sel;
        is_main = (cur.kind == mem_pins_pkg::CYC_MAIN) && !bios_sel
                  && !os_sel;
        bank = cur.addr[23];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state <= mem_pins_pkg::ST_IDLE;
            cur   <= '0;
        end
        else if (i_ce)
        begin
            unique case (state)
                mem_pins_pkg::ST_IDLE:
                    if (i_req_valid)
                    begin
                        cur   <= i_req;
                        state <= mem_pins_pkg::ST_ROW;
                    end
                mem_pins_pkg::ST_ROW:
                    state <= mem_pins_pkg::ST_COL;
                mem_pins_pkg::ST_COL:
                    state <= mem_pins_pkg::ST_END;
                mem_pins_pkg::ST_END:
                    state <= mem_pins_pkg::ST_IDLE;
            endcase
        end
    end

    logic [3:0]  next_col;
    logic [1:0]  next_row;
    logic [11:0] next_ma;
    logic        next_we;
    logic        act;
    logic        col_ph;

    always_comb
    begin
        act = (state == mem_pins_pkg::ST_ROW)
           || (state == mem_pins_pkg::ST_COL);
        col_ph = (state == mem_pins_pkg::ST_COL);
        next_col = 4'hF;
        next_row = 2'h3;
        next_ma  = '0;
        next_we  = 1'b1;
        if (act && is_main && !i_sram_mode)
        begin
            next_row[bank] = 1'b0;
            if (col_ph)
            begin
                next_col[{bank, 1'b0}] = !cur.byte_en[0];
                next_col[{bank, 1'b1}] = !cur.byte_en[1];
            end
            next_ma[10:0] = col_ph ? cur.addr[11:1] : cur.addr[22:12];
            next_we = !(col_ph && cur.write);
        end
        else if (act && is_main)
        begin
            next_col[{bank, 1'b0}] = !cur.byte_en[0];
            next_col[{bank, 1'b1}] = !cur.byte_en[1];
            next_ma = cur.addr[23:mem_pins_pkg::SA_HI_LSB];
            next_we = !(col_ph && cur.write);
        end
        else if (act && cur.kind != mem_pins_pkg::CYC_IO)
        begin
            next_ma = {cur.addr[12], cur.addr[13], cur.addr[23:14]};
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_col_strobe_n       <= 4'hF;
            o_row_strobe_n       <= 2'h3;
            o_mem_addr_out       <= '0;
            o_mem_write_strobe_n <= 1'b1;
            o_bios_rom_select_n  <= 1'b1;
            o_os_rom_select_n    <= 1'b1;
            o_sys_addr_low       <= '0;
            o_busy               <= 1'b0;
        end
        else if (i_ce)
        begin
            o_col_strobe_n       <= next_col;
            o_row_strobe_n       <= next_row;
            o_mem_addr_out       <= next_ma;
            o_mem_write_strobe_n <= next_we;
            o_bios_rom_select_n  <= !(act && bios_sel);
            o_os_rom_select_n    <= !(act && os_sel);
            o_sys_addr_low <= {cur.addr[11:1],
                (cur.kind == mem_pins_pkg::CYC_LOCAL) ? cur.addr[0]
                                                      : 1'b0};
            o_busy <= (state != mem_pins_pkg::ST_IDLE) || i_req_valid;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_sys_data_bus_out <= '0;
            o_sys_data_bus_oe  <= 1'b0;
            o_core_rdata       <= '0;
            o_rdata_valid      <= 1'b0;
        end
        else if (i_ce)
        begin
            o_sys_data_bus_out <= i_core_wdata;
            o_sys_data_bus_oe  <= act && cur.write;
            // in dram mode the column strobe reaches the pins one cycle after the
            // column phase (sram: from the column phase on), so read data is only valid in the end phase
            o_rdata_valid      <= (state == mem_pins_pkg::ST_END)
                                  && !cur.write;
            if ((state == mem_pins_pkg::ST_END) && !cur.write)
                o_core_rdata <= i_sys_data_bus_in;
        end
    end

    property p_ras_before_cas;
        @(posedge i_clk) disable iff (i_reset)
        ($fell(o_col_strobe_n[0]) && !i_sram_mode) |->
            $past(o_row_strobe_n) != 2'h3;
    endproperty
    a_ras_before_cas: assert property (p_ras_before_cas)
        else $error("column strobe without prior row strobe");

    property p_excl;
        @(posedge i_clk) disable iff (i_reset)
        !(!o_bios_rom_select_n && !o_os_rom_select_n);
    endproperty
    a_excl: assert property (p_excl)
        else $error("both rom selects active");

    property p_boot;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && act && seg_is(cur.addr, mem_pins_pkg::BOOT_SEG))
            |=> !o_bios_rom_select_n;
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot segment missed bios select");

    property p_oe;
        @(posedge i_clk) disable iff (i_reset)
        o_sys_data_bus_oe |-> $past(cur.write);
    endproperty
    a_oe: assert property (p_oe)
        else $error("data bus driven on a read");

    property p_we_cas;
        @(posedge i_clk) disable iff (i_reset)
        !o_mem_write_strobe_n |-> !(&o_col_strobe_n);
    endproperty
    a_we_cas: assert property (p_we_cas)
        else $error("write strobe without a lane strobe");

    property p_cas_row;
        @(posedge i_clk) disable iff (i_reset)
        (!(&o_col_strobe_n) && !i_sram_mode) |-> o_row_strobe_n != 2'h3;
    endproperty
    a_cas_row: assert property (p_cas_row)
        else $error("column strobe outside a row cycle");

    property p_excl_main;
        @(posedge i_clk) disable iff (i_reset)
        !(&o_col_strobe_n) |-> (o_bios_rom_select_n && o_os_rom_select_n);
    endproperty
    a_excl_main: assert property (p_excl_main)
        else $error("rom select during main memory strobe");

    property p_rdv_pulse;
        @(posedge i_clk) disable iff (i_reset)
        o_rdata_valid |=> !o_rdata_valid;
    endproperty
    a_rdv_pulse: assert property (p_rdv_pulse)
        else $error("read data valid longer than one cycle");

    property p_cas_rel;
        @(posedge i_clk) disable iff (i_reset)
        $rose(&o_row_strobe_n) |-> (&o_col_strobe_n);
    endproperty
    a_cas_rel: assert property (p_cas_rel)
        else $error("column strobe held past row release");
endmodule

// File: tb/mem_model.sv
`timescale 1ns/100ps
module mem_model
(
    input  wire logic        i_clk,
    input  wire logic [3:0]  i_col_n,
    input  wire logic        i_we_n,
    input  wire logic [11:0] i_ma,
    output logic [15:0]      o_data
);
    logic [15:0] junk = 16'hA5A5;
    // a released bus flips each cycle so stale data never reads right
    always_ff @(posedge i_clk)
    begin
        junk <= ~junk;
    end
    assign o_data = (!(&i_col_n) && i_we_n) ? {i_ma[10:0], 5'h13} : junk;
endmodule

// File: tb/memory_bus_pin_interface_tb_top.sv
`timescale 1ns/100ps
module memory_bus_pin_interface_tb_top;
    logic i_clk = 1'b0, i_reset = 1'b1, vld = 1'b0, srm = 1'b0;
    logic bpg = 1'b0, opg = 1'b0, pbh = 1'b0, poh = 1'b0, odh = 1'b0;
    logic [4:0] wen = 5'h00;
    logic [15:0] wd = 16'h0000, din, rd, dout;
    mem_pins_pkg::bus_req_t rq = '0;
    logic bsy, rv, we_n, bs_n, os_n, oe;
    logic [3:0] col_n;
    logic [1:0] row_n;
    logic [11:0] ma, sal;
    int error_cnt = 0, checks_done = 0;
    memory_bus_pin_interface dut_u (.i_clk(i_clk), .i_reset(i_reset),
        .i_ce(1'b1), .i_req_valid(vld), .i_req(rq), .i_core_wdata(wd),
        .i_sram_mode(srm), .i_bios_paged(bpg), .i_os_paged(opg),
        .i_paged_bios_hit(pbh), .i_paged_os_hit(poh), .i_os_direct_hit(odh),
        .i_bios_win_en(wen), .i_sys_data_bus_in(din), .o_busy(bsy),
        .o_core_rdata(rd), .o_rdata_valid(rv), .o_col_strobe_n(col_n),
        .o_row_strobe_n(row_n), .o_mem_addr_out(ma), .o_sys_addr_low(sal),
        .o_mem_write_strobe_n(we_n), .o_bios_rom_select_n(bs_n),
        .o_os_rom_select_n(os_n), .o_sys_data_bus_out(dout),
        .o_sys_data_bus_oe(oe));
    mem_model mem_u (.i_clk(i_clk), .i_col_n(col_n), .i_we_n(we_n),
        .i_ma(ma), .o_data(din));
    initial
    begin
        forever #25 i_clk = ~i_clk;
    end
    task automatic chk(input string nm, input logic [15:0] s, e);
        checks_done++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic bios(input logic [23:0] a);
        logic [7:0] s;
        s = a[23:16];
        return (s == 8'hFF) || (bpg ? pbh : (wen[4] && s == 8'h0F) ||
            (wen[3] && s == 8'h0E) || (wen[2] && s == 8'h0D) ||
            (wen[1] && s == 8'h0C) || (wen[0] && s == 8'h0A));
    endfunction
    task automatic run(input logic [23:0] a, input int k);
        logic [1:0] be;
        logic b;
        logic m;
        be = 2'($urandom_range(1, 3));
        @(posedge i_clk);
        rq <= '{a, be, 1'($urandom), mem_pins_pkg::cyc_kind_t'(k)};
        {srm, bpg, opg, pbh, poh, odh} <= 6'($urandom);
        wen <= 5'($urandom);
        wd <= 16'($urandom);
        vld <= 1'b1;
        @(posedge i_clk);
        vld <= 1'b0;
        b = a[23];
        // rom selects take the cycle away from main memory
        m = (k == 0) && !bios(a) && !(opg ? poh : odh);
        @(negedge i_clk);
        if (m)
        begin
            if (!srm)
            begin
                repeat (8) if (row_n === 2'h3) @(negedge i_clk);
                chk("row", row_n, {14'h0000, ~(2'h1 << b)});
                chk("ma_row", ma[10:0], a[22:12]);
            end
            repeat (8) if (col_n === 4'hF) @(negedge i_clk);
            chk("col", col_n, {12'h000, ~(4'(be) << (2 * b))});
            chk("ma", ma, srm ? a[23:12] : 16'(a[11:1]));
            if (srm)
                chk("sal", sal, {a[11:1], 1'b0});
            // sram selects lead the write strobe by one cycle
            if (srm)
                @(negedge i_clk);
            chk("we", we_n, !rq.write);
            chk("sel", {bs_n, os_n}, 16'h3);
            if (rq.write)
                chk("wr", {oe, dout}, {1'b1, wd});
            else
            begin
                repeat (8) if (rv !== 1'b1) @(negedge i_clk);
                chk("rd", rd, {srm ? a[22:12] : a[11:1], 5'h13});
            end
        end
        else
        begin
            repeat (2) @(negedge i_clk);
            chk("str", {col_n, row_n}, 16'h3F);
            if (k != 2)
                chk("ma_ext", ma, {a[12], a[13], a[23:14]});
            else
                chk("ma_io", ma, 16'h0000);
            chk("bios", bs_n, !bios(a));
            chk("os", os_n, bios(a) || !(opg ? poh : odh));
            if (k == 1)
                chk("sal_l", sal, a[11:0]);
        end
        repeat (8) if (bsy !== 1'b0) @(negedge i_clk);
        $display("test kind %0d addr %h end", k, a);
    endtask
    initial
    begin
        #200000;
        error_cnt++;
        end_sim();
    end
    initial
    begin
        logic [23:0] cor [6];
        cor = '{24'hFF0000, 24'hFFFFFF, 24'h0F0000, 24'h0AFFFF,
            24'h0B0000, 24'h0EFFFF};
        void'($urandom(5186));
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        for (int i = 0; i < 48; i++)
            run(i < 24 ? cor[i % 6] : 24'($urandom), i % 4);
        end_sim();
    end
endmodule
